// File: design/hfl_pkg.sv
// Shared constants for the HDLC FIFO level and transmit count block
package hfl_pkg;
	localparam int unsigned HFL_DEPTH = 128;
	localparam int unsigned HFL_PTR_W = 7;
	localparam int unsigned HFL_CNT_W = 8;
	localparam int unsigned HFL_WORD_W = 9;
	// Register map (byte addresses on the 5-bit port)
	localparam logic [4:0] HFL_ADDR_FIFO = 5'h10;
	localparam logic [4:0] HFL_ADDR_CTRL2 = 5'h11;
	localparam logic [4:0] HFL_ADDR_STATUS = 5'h12;
	localparam logic [4:0] HFL_ADDR_LOW_CNT = 5'h1A;
	localparam logic [4:0] HFL_ADDR_FULL_LVL = 5'h1D;
	localparam logic [4:0] HFL_ADDR_IRQ_THR = 5'h1E;
	localparam logic [4:0] HFL_ADDR_EXT_CNT = 5'h1F;
	// Field positions
	localparam int unsigned HFL_RX_SEL_POS = 4;
	localparam int unsigned HFL_TX_SEL_POS = 0;
	localparam int unsigned HFL_CYCLE_POS = 0;
	localparam int unsigned HFL_EOP_POS = 8;
	localparam int unsigned HFL_ST_RX_FULL = 0;
	localparam int unsigned HFL_ST_TX_FULL = 1;
	localparam int unsigned HFL_ST_RX_IRQ = 2;
	localparam int unsigned HFL_ST_TX_IRQ = 3;
	localparam int unsigned HFL_ST_RX_EMPTY = 4;
	localparam int unsigned HFL_ST_RX_EOP = 5;
	localparam int unsigned HFL_ST_TX_EMPTY = 6;
	// Reset values and masks
	localparam logic [7:0] HFL_SEL_MASK = 8'h77;
	localparam logic [7:0] HFL_CTRL2_MASK = 8'h01;
	localparam logic [7:0] HFL_REG_RST = 8'h00;
	localparam logic [15:0] HFL_LEN_RST = 16'h0000;
	// Level and threshold encodings
	localparam logic [7:0] HFL_FULL_STEP = 8'h10;
	localparam logic [7:0] HFL_RX_THR_BASE = 8'h40;
	localparam logic [7:0] HFL_TX_THR_BASE = 8'h08;
	localparam logic [7:0] HFL_THR_STEP = 8'h08;
endpackage

// File: design/hfl_stream_if.sv
// Valid/ready word carrier between the FIFO core and the output buffer
`timescale 1ns/1ps
interface hfl_stream_if;
	logic valid;
	logic ready;
	logic [8:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// File: design/hfl_skid2.sv
// Two-entry buffer so a stalled receiver loses no transmit word
`timescale 1ns/1ps
module hfl_skid2
	import hfl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	hfl_stream_if.snk in_s,
	hfl_stream_if.src out_s
);
	logic [HFL_WORD_W-1:0] slot0_ff, slot1_ff, nxt_slot0, nxt_slot1;
	logic [1:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign in_s.ready = (cnt_ff != 2'h2);
	assign out_s.valid = (cnt_ff != 2'h0);
	assign out_s.data = slot0_ff;
	assign push = ce & in_s.valid & in_s.ready;
	assign pop = ce & out_s.valid & out_s.ready;

	always_comb begin
		nxt_slot0 = slot0_ff;
		nxt_slot1 = slot1_ff;
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			if (cnt_ff == 2'h0) nxt_slot0 = in_s.data;
			else nxt_slot1 = in_s.data;
			nxt_cnt = cnt_ff + 2'h1;
		end else if (pop && !push) begin
			nxt_slot0 = slot1_ff;
			nxt_cnt = cnt_ff - 2'h1;
		end else if (pop && push) begin
			if (cnt_ff == 2'h1) begin
				nxt_slot0 = in_s.data;
			end else begin
				nxt_slot0 = slot1_ff;
				nxt_slot1 = in_s.data;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot0_ff <= 9'h000;
			slot1_ff <= 9'h000;
			cnt_ff <= 2'h0;
		end else if (ce) begin
			slot0_ff <= nxt_slot0;
			slot1_ff <= nxt_slot1;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// File: design/hfl_top.sv
// HDLC FIFO levels, interrupt thresholds and transmit byte counter
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Full-level register bits 6-4 pick receive full level 16..128 in steps of 16.
// - Full-level register bits 2-0 pick transmit full level 16..128 in steps of 16.
// - Threshold register bits 6-4 pick receive-full interrupt level 64..120, step 8.
// - Threshold register bits 2-0 pick transmit-low interrupt level 8..64, step 8.
// - Packet length is extended byte as high eight bits, low count byte below.
// - Extended byte reaches the counter only when the low count byte is written.
// - With the counter at one, the next transmit FIFO write is tagged end of packet.
// - The counter decrements on each accepted transmit FIFO write and holds at zero.
// - With the cycle bit set, the length reloads after each end-of-packet tag.
module hfl_top
	import hfl_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic rx_in_valid,
	output logic rx_in_ready,
	input wire logic [7:0] rx_in_data,
	input wire logic rx_in_eop,
	output logic tx_out_valid,
	input wire logic tx_out_ready,
	output logic [7:0] tx_out_data,
	output logic tx_out_eop,
	output logic rx_full_status,
	output logic tx_full_status,
	output logic rx_fifo_full_irq,
	output logic tx_fifo_low_irq
);
	//////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] full_lvl_ff, irq_thr_ff, ext_cnt_ff, ctrl2_ff, rdata_ff;
	logic [7:0] nxt_full_lvl, nxt_irq_thr, nxt_ext_cnt, nxt_ctrl2, nxt_rdata;
	logic [15:0] len_ff, bcnt_ff, nxt_len, nxt_bcnt;
	logic [HFL_PTR_W-1:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
	logic [HFL_PTR_W-1:0] nxt_tx_wp, nxt_tx_rp, nxt_rx_wp, nxt_rx_rp;
	logic [HFL_CNT_W-1:0] tx_cnt_ff, rx_cnt_ff, nxt_tx_cnt, nxt_rx_cnt;
	logic [3:0] flags_ff, nxt_flags;
	logic [HFL_WORD_W-1:0] tx_mem [HFL_DEPTH];
	logic [HFL_WORD_W-1:0] rx_mem [HFL_DEPTH];
	logic [HFL_WORD_W-1:0] tx_wword, rx_head;
	logic [2:0] rx_lvl_sel, tx_lvl_sel, rx_thr_sel, tx_thr_sel;
	logic [7:0] rx_lvl, tx_lvl, rx_thr, tx_thr, status;
	logic wr_low, wr_ext, tx_wr, tx_pop, rx_push, rx_pop, cycle_en;
	hfl_stream_if tx_s ();
	hfl_stream_if out_s ();

	//////////////////////////////////////////////////////////////////////////
	// Decode and handshakes
	assign wr_low = ce & reg_wr & (reg_addr == HFL_ADDR_LOW_CNT);
	assign wr_ext = ce & reg_wr & (reg_addr == HFL_ADDR_EXT_CNT);
	assign tx_wr = ce & reg_wr & (reg_addr == HFL_ADDR_FIFO) & (tx_cnt_ff != 8'h80);
	assign rx_pop = ce & reg_rd & (reg_addr == HFL_ADDR_FIFO) & (rx_cnt_ff != 8'h00);
	assign rx_in_ready = (rx_cnt_ff != 8'h80);
	assign rx_push = ce & rx_in_valid & rx_in_ready;
	assign tx_s.valid = (tx_cnt_ff != 8'h00);
	assign tx_s.data = tx_mem[tx_rp_ff];
	assign tx_pop = ce & tx_s.valid & tx_s.ready;
	assign rx_head = rx_mem[rx_rp_ff];
	assign cycle_en = ctrl2_ff[HFL_CYCLE_POS];
	assign tx_wword = {(bcnt_ff == 16'h0001), reg_wdata};

	//////////////////////////////////////////////////////////////////////////
	// Level and threshold selection
	assign rx_lvl_sel = full_lvl_ff[HFL_RX_SEL_POS +: 3];
	assign tx_lvl_sel = full_lvl_ff[HFL_TX_SEL_POS +: 3];
	assign rx_thr_sel = irq_thr_ff[HFL_RX_SEL_POS +: 3];
	assign tx_thr_sel = irq_thr_ff[HFL_TX_SEL_POS +: 3];
	assign rx_lvl = 8'(HFL_FULL_STEP * ({5'h00, rx_lvl_sel} + 8'h01));
	assign tx_lvl = 8'(HFL_FULL_STEP * ({5'h00, tx_lvl_sel} + 8'h01));
	assign rx_thr = 8'(HFL_RX_THR_BASE + HFL_THR_STEP * {5'h00, rx_thr_sel});
	assign tx_thr = 8'(HFL_TX_THR_BASE + HFL_THR_STEP * {5'h00, tx_thr_sel});

	always_comb begin
		status = 8'h00;
		status[HFL_ST_RX_FULL] = flags_ff[0];
		status[HFL_ST_TX_FULL] = flags_ff[1];
		status[HFL_ST_RX_IRQ] = flags_ff[2];
		status[HFL_ST_TX_IRQ] = flags_ff[3];
		status[HFL_ST_RX_EMPTY] = (rx_cnt_ff == 8'h00);
		status[HFL_ST_RX_EOP] = (rx_cnt_ff != 8'h00) & rx_head[HFL_EOP_POS];
		status[HFL_ST_TX_EMPTY] = (tx_cnt_ff == 8'h00);
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers and read data
	always_comb begin
		nxt_full_lvl = full_lvl_ff;
		nxt_irq_thr = irq_thr_ff;
		nxt_ext_cnt = ext_cnt_ff;
		nxt_ctrl2 = ctrl2_ff;
		nxt_rdata = rdata_ff;
		if (ce && reg_wr) begin
			unique case (reg_addr)
				HFL_ADDR_FULL_LVL: nxt_full_lvl = reg_wdata & HFL_SEL_MASK;
				HFL_ADDR_IRQ_THR: nxt_irq_thr = reg_wdata & HFL_SEL_MASK;
				HFL_ADDR_EXT_CNT: nxt_ext_cnt = reg_wdata;
				HFL_ADDR_CTRL2: nxt_ctrl2 = reg_wdata & HFL_CTRL2_MASK;
				default: ;
			endcase
		end
		if (ce && reg_rd) begin
			unique case (reg_addr)
				HFL_ADDR_FIFO: nxt_rdata = (rx_cnt_ff != 8'h00) ? rx_head[7:0] : 8'h00;
				HFL_ADDR_CTRL2: nxt_rdata = ctrl2_ff;
				HFL_ADDR_STATUS: nxt_rdata = status;
				HFL_ADDR_LOW_CNT: nxt_rdata = len_ff[7:0];
				HFL_ADDR_FULL_LVL: nxt_rdata = full_lvl_ff;
				HFL_ADDR_IRQ_THR: nxt_rdata = irq_thr_ff;
				HFL_ADDR_EXT_CNT: nxt_rdata = ext_cnt_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Transmit byte counter
	always_comb begin
		nxt_len = len_ff;
		nxt_bcnt = bcnt_ff;
		if (wr_low) begin
			nxt_len = {ext_cnt_ff, reg_wdata};
			nxt_bcnt = {ext_cnt_ff, reg_wdata};
		end else if (tx_wr && bcnt_ff != 16'h0000) begin
			if (bcnt_ff == 16'h0001 && cycle_en) nxt_bcnt = len_ff;
			else nxt_bcnt = bcnt_ff - 16'h0001;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// FIFO pointers, occupancy and status flags
	always_comb begin
		nxt_tx_wp = tx_wr ? tx_wp_ff + 7'h01 : tx_wp_ff;
		nxt_tx_rp = tx_pop ? tx_rp_ff + 7'h01 : tx_rp_ff;
		nxt_rx_wp = rx_push ? rx_wp_ff + 7'h01 : rx_wp_ff;
		nxt_rx_rp = rx_pop ? rx_rp_ff + 7'h01 : rx_rp_ff;
		nxt_tx_cnt = tx_cnt_ff + {7'h00, tx_wr} - {7'h00, tx_pop};
		nxt_rx_cnt = rx_cnt_ff + {7'h00, rx_push} - {7'h00, rx_pop};
		nxt_flags[0] = (rx_cnt_ff >= rx_lvl);
		nxt_flags[1] = (tx_cnt_ff >= tx_lvl);
		nxt_flags[2] = (rx_cnt_ff >= rx_thr);
		nxt_flags[3] = (tx_cnt_ff <= tx_thr);
	end

	always_ff @(posedge clk) begin
		if (tx_wr) tx_mem[tx_wp_ff] <= tx_wword;
		if (rx_push) rx_mem[rx_wp_ff] <= {rx_in_eop, rx_in_data};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			full_lvl_ff <= HFL_REG_RST;
			irq_thr_ff <= HFL_REG_RST;
			ext_cnt_ff <= HFL_REG_RST;
			ctrl2_ff <= HFL_REG_RST;
			rdata_ff <= HFL_REG_RST;
			len_ff <= HFL_LEN_RST;
			bcnt_ff <= HFL_LEN_RST;
			tx_wp_ff <= 7'h00;
			tx_rp_ff <= 7'h00;
			rx_wp_ff <= 7'h00;
			rx_rp_ff <= 7'h00;
			tx_cnt_ff <= 8'h00;
			rx_cnt_ff <= 8'h00;
			flags_ff <= 4'h0;
		end else if (ce) begin
			full_lvl_ff <= nxt_full_lvl;
			irq_thr_ff <= nxt_irq_thr;
			ext_cnt_ff <= nxt_ext_cnt;
			ctrl2_ff <= nxt_ctrl2;
			rdata_ff <= nxt_rdata;
			len_ff <= nxt_len;
			bcnt_ff <= nxt_bcnt;
			tx_wp_ff <= nxt_tx_wp;
			tx_rp_ff <= nxt_tx_rp;
			rx_wp_ff <= nxt_rx_wp;
			rx_rp_ff <= nxt_rx_rp;
			tx_cnt_ff <= nxt_tx_cnt;
			rx_cnt_ff <= nxt_rx_cnt;
			flags_ff <= nxt_flags;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Output buffer and outputs
	hfl_skid2 u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.in_s(tx_s.snk),
		.out_s(out_s.src)
	);

	assign tx_out_valid = out_s.valid;
	assign out_s.ready = tx_out_ready;
	assign tx_out_data = out_s.data[7:0];
	assign tx_out_eop = out_s.data[HFL_EOP_POS];
	assign reg_rdata = rdata_ff;
	assign rx_full_status = flags_ff[0];
	assign tx_full_status = flags_ff[1];
	assign rx_fifo_full_irq = flags_ff[2];
	assign tx_fifo_low_irq = flags_ff[3];

	//////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	rx_level_a: assert property (
		(ce && rx_lvl_sel == 3'h7 && rx_cnt_ff == 8'h7F) |=> !rx_full_status)
		else $error("receive full status set below level 128");
	tx_level_a: assert property (
		(ce && tx_lvl_sel == 3'h0 && tx_cnt_ff == 8'h10) |=> tx_full_status)
		else $error("transmit full status missing at level 16");
	rx_thresh_a: assert property (
		(ce && rx_thr_sel == 3'h1 && rx_cnt_ff == 8'h47) |=> !rx_fifo_full_irq)
		else $error("receive full irq set below threshold 72");
	tx_thresh_a: assert property (
		(ce && tx_thr_sel == 3'h7 && tx_cnt_ff == 8'h40) |=> tx_fifo_low_irq)
		else $error("transmit low irq missing at threshold 64");
	len_load_a: assert property (
		wr_low |=> (bcnt_ff == {$past(ext_cnt_ff), $past(reg_wdata)}) && (len_ff == bcnt_ff))
		else $error("low count write did not load the full length");
	ext_hold_a: assert property (
		wr_ext |=> $stable(bcnt_ff))
		else $error("extended byte reached the counter early");
	eop_tag_a: assert property (
		tx_wr |=> (tx_mem[$past(tx_wp_ff)][HFL_EOP_POS] == ($past(bcnt_ff) == 16'h0001)))
		else $error("end-of-packet tag wrong for transmit write");
	dec_step_a: assert property (
		(tx_wr && bcnt_ff > 16'h0001) |=> bcnt_ff == $past(bcnt_ff) - 16'h0001)
		else $error("counter did not decrement after transmit write");
	cycle_reload_a: assert property (
		(tx_wr && bcnt_ff == 16'h0001) |=> bcnt_ff == ($past(cycle_en) ? len_ff : 16'h0000))
		else $error("counter reload after end of packet wrong");
	full_track_a: assert property (
		ce ##1 ce |=> rx_full_status == ($past(rx_cnt_ff) >= $past(rx_lvl)))
		else $error("receive full status does not track occupancy");
endmodule

// File: testbench/hfl_tx_sink.sv
// Transmit-side partner: takes words with random or forced stalls
`timescale 1ns/1ps
module hfl_tx_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	output logic ready
);
	// Ready moves just after the edge; hold forces a long stall
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'h0;
		end else begin
			ready <= #1 !hold && ($urandom % 4 != 0);
		end
	end
endmodule

// File: testbench/test_hdlc_fifo_level_and_tx_count.sv
// Self-checking bench for FIFO levels, thresholds and transmit count
`timescale 1ns/1ps
module test_hdlc_fifo_level_and_tx_count;
	import hfl_pkg::*;
	logic clk, rst_n, ce, reg_wr, reg_rd, rx_in_valid, rx_in_eop, tx_out_ready, hold;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, rx_in_data, reg_rdata, tx_out_data;
	logic tx_out_valid, tx_out_eop, rx_full_status, tx_full_status;
	logic rx_fifo_full_irq, tx_fifo_low_irq, rx_in_ready;
	int bad_count = 0, n_tests = 0, cnt = 0, len = 0, rx_n = 0, tx_n = 0, k, to;
	logic [7:0] ext = 8'h00, fl = 8'h00, th = 8'h00, cyc = 8'h00;
	logic [8:0] exp_q[$];
	logic [7:0] rxq[$];
	hfl_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data),
		.rx_in_eop(rx_in_eop), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
		.tx_out_data(tx_out_data), .tx_out_eop(tx_out_eop), .rx_full_status(rx_full_status),
		.tx_full_status(tx_full_status), .rx_fifo_full_irq(rx_fifo_full_irq),
		.tx_fifo_low_irq(tx_fifo_low_irq));
	hfl_tx_sink u_sink (.clk(clk), .rst_n(rst_n), .hold(hold), .ready(tx_out_ready));
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// Register write plus the reference model of the transmit counter
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr = 1'h0;
		case (a)
			HFL_ADDR_FULL_LVL: fl = d & HFL_SEL_MASK;
			HFL_ADDR_IRQ_THR: th = d & HFL_SEL_MASK;
			HFL_ADDR_CTRL2: cyc = d & HFL_CTRL2_MASK;
			HFL_ADDR_EXT_CNT: ext = d;
			HFL_ADDR_LOW_CNT: begin
				len = {ext, d};
				cnt = len;
			end
			HFL_ADDR_FIFO: if (tx_n < 130) begin
				exp_q.push_back({cnt == 1, d});
				cnt = (cnt == 1) ? (cyc[0] ? len : 0) : (cnt > 1 ? cnt - 1 : 0);
				tx_n++;
			end
			default: ;
		endcase
		tick();
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		reg_rd = 1'h1;
		reg_addr = a;
		tick();
		reg_rd = 1'h0;
		chk(reg_rdata, e);
		tick();
	endtask
	task automatic drain();
		hold = 1'h0;
		for (int i = 0; i < 3000 && exp_q.size() != 0; i++) tick();
		chk(exp_q.size(), 0);
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// Every word leaving the buffer is compared with the model queue
	always @(posedge clk) begin
		if (rst_n === 1'h1 && tx_out_valid === 1'h1 && tx_out_ready === 1'h1) begin
			chk({tx_out_eop, tx_out_data}, exp_q.size() ? exp_q.pop_front() : 16'hFFFF);
			tx_n--;
		end
	end
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		bad_count++;
		give_verdict();
	end
	initial begin
		rst_n = 1'h0;
		ce = 1'h1;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		rx_in_valid = 1'h0;
		rx_in_data = 8'h00;
		rx_in_eop = 1'h0;
		hold = 1'h0;
		void'($urandom(46087));
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'h1;
		rd(HFL_ADDR_FULL_LVL, HFL_REG_RST);
		rd(HFL_ADDR_IRQ_THR, HFL_REG_RST);
		// Write with the clock enable low must not land
		ce = 1'h0;
		reg_wr = 1'h1;
		reg_addr = HFL_ADDR_FULL_LVL;
		reg_wdata = 8'h35;
		tick();
		reg_wr = 1'h0;
		ce = 1'h1;
		tick();
		rd(HFL_ADDR_FULL_LVL, HFL_REG_RST);
		wr(HFL_ADDR_FULL_LVL, 8'hFF);
		rd(HFL_ADDR_FULL_LVL, 8'h77);
		rd(5'h05, 8'h00);
		// Length three repeating, then one long packet of 0x0102 bytes
		wr(HFL_ADDR_EXT_CNT, 8'h00);
		wr(HFL_ADDR_CTRL2, 8'h01);
		wr(HFL_ADDR_LOW_CNT, 8'h03);
		for (k = 0; k < 7; k++) begin
			wr(HFL_ADDR_FIFO, 8'($urandom));
			tick();
		end
		wr(HFL_ADDR_CTRL2, 8'h00);
		wr(HFL_ADDR_EXT_CNT, 8'h01);
		wr(HFL_ADDR_LOW_CNT, 8'h02);
		wr(HFL_ADDR_EXT_CNT, 8'h00);
		rd(HFL_ADDR_LOW_CNT, 8'h02);
		for (k = 0; k < 260; k++) begin
			wr(HFL_ADDR_FIFO, 8'($urandom));
			tick();
		end
		drain();
		// Fill both FIFOs past the top under random level settings
		hold = 1'h1;
		repeat (2) tick();
		for (k = 1; k <= 131; k++) begin
			wr(HFL_ADDR_FULL_LVL, 8'($urandom));
			wr(HFL_ADDR_IRQ_THR, 8'($urandom));
			chk(rx_in_ready, rx_n < 128);
			rx_in_valid = 1'h1;
			rx_in_data = 8'($urandom);
			rx_in_eop = 1'($urandom);
			if (rx_n < 128) rxq.push_back(rx_in_data);
			tick();
			rx_in_valid = 1'h0;
			rx_n = rxq.size();
			wr(HFL_ADDR_FIFO, 8'($urandom));
			repeat (3) tick();
			to = (tx_n > 2) ? tx_n - 2 : 0;
			chk(rx_full_status, rx_n >= 16 * (fl[6:4] + 1));
			chk(tx_full_status, to >= 16 * (fl[2:0] + 1));
			chk(rx_fifo_full_irq, rx_n >= 64 + 8 * th[6:4]);
			chk(tx_fifo_low_irq, to <= 8 + 8 * th[2:0]);
		end
		rd(HFL_ADDR_FULL_LVL, fl);
		drain();
		while (rxq.size() != 0) rd(HFL_ADDR_FIFO, rxq.pop_front());
		rd(HFL_ADDR_FIFO, 8'h00);
		// Both FIFOs empty: only the empty bits and the transmit-low irq stand
		rd(HFL_ADDR_STATUS, 8'h58);
		give_verdict();
	end
endmodule
